// ==== rtl/adc_config_register_map.sv ====
// Sixteen byte-wide configuration, calibration and result registers.
// Assumes a command engine on ref_clk presenting one-cycle read/write
// strobes with an address; result and ready come from the filter.
//
// Notes on behaviour
// - Sixteen byte registers at consecutive addresses
// - Gain register upper nibble fixed identification
// - Gain bit three enables burnout sources
// - Gain code selects two to code
// - Channel upper nibble picks positive input
// - Channel lower nibble negative, resets one
// - Analog bit seven mirrors ready pin
// - Analog bit six selects unipolar format
// - Analog bit five selects slower modulator
// - Analog bit four enables input buffer
// - Analog bit three selects result LSB-first
// - Analog bit two halves input range
// - Analog bits one-zero select data rate
// - Trim register sign and magnitude, resets zero
// - Pin data drives outputs, reads pins
// - Direction bit zero output, resets inputs
// - Function bit one digital, resets analog
// - Four-pin variant leaves upper bits unused
// - Calibration coefficients low byte first
// - Result read-only, high byte first
// - Burst addresses wrap past last register
`timescale 1ns/1ps
`default_nettype none

module adc_config_register_map
	import adc_regs_pkg::*;
#(
	parameter int PIN_COUNT = 8,
	parameter logic [3:0] IDENT_BITS = 4'hA
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic [3:0] next_burst_addr,
	input wire logic result_ready_n,
	input wire logic [23:0] conversion_result,
	input wire logic cal_ofs_load,
	input wire logic [23:0] cal_ofs_value,
	input wire logic cal_fs_load,
	input wire logic [23:0] cal_fs_value,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_digital,
	output analog_cfg_t analog_cfg,
	output logic [23:0] offset_coef,
	output logic [23:0] full_scale_coef
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [3:0] gain_low;
	logic [7:0] channel_sel;
	logic [6:0] analog_low;
	logic [7:0] trim;
	logic [7:0] pin_data;
	logic [7:0] pin_direction;
	logic [7:0] pin_function_select;
	logic [23:0] ofs;
	logic [23:0] fs;
	logic [2:0] ready_sync;
	logic ready_seen;
	logic [7:0] pin_seen;
	access_state_t state;
	access_state_t next_state;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// sixteen one-hot selects
	wire logic [15:0] sel = 16'h0001 << reg_addr;
	wire logic wr = reg_write;
	wire logic [7:0] pin_mask = (PIN_COUNT >= 8) ? 8'hFF : 8'h0F;

	wire logic ready_agree = (ready_sync[1] == ready_sync[2]);
	wire logic next_ready = ready_agree ? ready_sync[2] : ready_seen;

	wire logic [7:0] rd_gain = {IDENT_BITS, gain_low};
	wire logic [7:0] rd_analog = {ready_seen, analog_low};
	wire logic [7:0] rd_pins = pin_seen & pin_mask;

	logic [7:0] next_rdata;
	always_comb begin
		case (reg_addr)
			ADDR_GAIN_BURNOUT: next_rdata = rd_gain;
			ADDR_CHANNEL: next_rdata = channel_sel;
			ADDR_ANALOG: next_rdata = rd_analog;
			ADDR_TRIM: next_rdata = trim;
			ADDR_PIN_DATA: next_rdata = rd_pins;
			ADDR_PIN_DIR: next_rdata = pin_direction;
			ADDR_PIN_FUNC: next_rdata = pin_function_select;
			ADDR_OFS_LOW: next_rdata = ofs[7:0];
			ADDR_OFS_MID: next_rdata = ofs[15:8];
			ADDR_OFS_HIGH: next_rdata = ofs[23:16];
			ADDR_FS_LOW: next_rdata = fs[7:0];
			ADDR_FS_MID: next_rdata = fs[15:8];
			ADDR_FS_HIGH: next_rdata = fs[23:16];
			ADDR_RES_HIGH: next_rdata = conversion_result[23:16];
			ADDR_RES_MID: next_rdata = conversion_result[15:8];
			ADDR_RES_LOW: next_rdata = conversion_result[7:0];
			default: next_rdata = 8'h00;
		endcase
	end

	// State tracks whether the previous cycle held a write
	always_comb begin
		case (state)
			ACC_IDLE: next_state = wr ? ACC_WRITE : ACC_IDLE;
			ACC_WRITE: next_state = wr ? ACC_WRITE : ACC_IDLE;
			default: next_state = ACC_IDLE;
		endcase
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_low <= RST_GAIN_LOW;
			channel_sel <= RST_CHANNEL;
			analog_low <= RST_ANALOG;
			trim <= RST_TRIM;
			pin_data <= RST_PIN_DATA;
			pin_direction <= RST_PIN_DIR;
			pin_function_select <= RST_PIN_FUNC;
		end else if (wr) begin
			if (sel[ADDR_GAIN_BURNOUT])
				gain_low <= reg_wdata[3:0];
			if (sel[ADDR_CHANNEL])
				channel_sel <= reg_wdata;
			if (sel[ADDR_ANALOG])
				analog_low <= reg_wdata[6:0];
			if (sel[ADDR_TRIM])
				trim <= reg_wdata;
			if (sel[ADDR_PIN_DATA])
				pin_data <= reg_wdata & pin_mask;
			if (sel[ADDR_PIN_DIR])
				pin_direction <= reg_wdata | ~pin_mask;
			if (sel[ADDR_PIN_FUNC])
				pin_function_select <= reg_wdata & pin_mask;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ofs <= RST_OFS;
			fs <= RST_FS;
		end else begin
			if (cal_ofs_load)
				ofs <= cal_ofs_value;
			else if (wr && sel[ADDR_OFS_LOW])
				ofs[7:0] <= reg_wdata;
			else if (wr && sel[ADDR_OFS_MID])
				ofs[15:8] <= reg_wdata;
			else if (wr && sel[ADDR_OFS_HIGH])
				ofs[23:16] <= reg_wdata;
			if (cal_fs_load)
				fs <= cal_fs_value;
			else if (wr && sel[ADDR_FS_LOW])
				fs[7:0] <= reg_wdata;
			else if (wr && sel[ADDR_FS_MID])
				fs[15:8] <= reg_wdata;
			else if (wr && sel[ADDR_FS_HIGH])
				fs[23:16] <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_sync <= 3'b111;
			ready_seen <= 1'b1;
		end else begin
			ready_sync <= {ready_sync[1:0], result_ready_n};
			ready_seen <= next_ready;
		end
	end

	// ----------------------------------------
	// Pin filters, one per dual-purpose pin
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			logic [2:0] pin_shift;
			// level taken once two stages agree
			wire logic agree = (pin_shift[1] == pin_shift[2]);
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_shift <= 3'b000;
					pin_seen[g] <= 1'b0;
				end else begin
					pin_shift <= {pin_shift[1:0], pin_in[g]};
					if (agree)
						pin_seen[g] <= pin_shift[2];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// digital outputs only
	wire logic [7:0] next_oe = pin_function_select & ~pin_direction & pin_mask;
	wire logic [3:0] next_addr = reg_addr + 4'h1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			next_burst_addr <= 4'h0;
			pin_out <= 8'h00;
			pin_oe <= 8'h00;
			pin_digital <= 8'h00;
			// Mirror the register reset values, not all zero
			analog_cfg <= '{
				positive_input_code: RST_CHANNEL[7:4],
				negative_input_code: RST_CHANNEL[3:0],
				offset_trim: RST_TRIM,
				default: '0
			};
			offset_coef <= RST_OFS;
			full_scale_coef <= RST_FS;
			state <= ACC_IDLE;
		end else begin
			state <= next_state;
			reg_rvalid <= reg_read;
			if (reg_read)
				reg_rdata <= next_rdata;
			if (reg_read || wr)
				next_burst_addr <= next_addr;
			pin_out <= pin_data & next_oe;
			pin_oe <= next_oe;
			pin_digital <= pin_function_select;
			analog_cfg.burnout_source_on <= gain_low[BIT_BURNOUT];
			analog_cfg.amp_gain_code <= gain_low[2:0];
			analog_cfg.positive_input_code <= channel_sel[7:4];
			analog_cfg.negative_input_code <= channel_sel[3:0];
			analog_cfg.unipolar <= analog_low[BIT_UNIPOLAR];
			analog_cfg.slow_modulator <= analog_low[BIT_SLOW_MOD];
			analog_cfg.input_buffer_on <= analog_low[BIT_BUFFER];
			analog_cfg.lsb_first <= analog_low[BIT_LSB_FIRST];
			analog_cfg.half_range <= analog_low[BIT_HALF_RANGE];
			analog_cfg.output_rate_code <= analog_low[1:0];
			analog_cfg.offset_trim <= trim;
			offset_coef <= ofs;
			full_scale_coef <= fs;
		end
	end

endmodule : adc_config_register_map

`default_nettype wire

// ==== rtl/adc_regs_pkg.sv ====
// Package for the converter configuration register bank.
// Assumes a byte-wide register port driven by a serial command engine.
package adc_regs_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam int REG_COUNT = 16;
	localparam logic [3:0] ADDR_GAIN_BURNOUT = 4'h0;
	localparam logic [3:0] ADDR_CHANNEL = 4'h1;
	localparam logic [3:0] ADDR_ANALOG = 4'h2;
	localparam logic [3:0] ADDR_TRIM = 4'h3;
	localparam logic [3:0] ADDR_PIN_DATA = 4'h4;
	localparam logic [3:0] ADDR_PIN_DIR = 4'h5;
	localparam logic [3:0] ADDR_PIN_FUNC = 4'h6;
	localparam logic [3:0] ADDR_OFS_LOW = 4'h7;
	localparam logic [3:0] ADDR_OFS_MID = 4'h8;
	localparam logic [3:0] ADDR_OFS_HIGH = 4'h9;
	localparam logic [3:0] ADDR_FS_LOW = 4'hA;
	localparam logic [3:0] ADDR_FS_MID = 4'hB;
	localparam logic [3:0] ADDR_FS_HIGH = 4'hC;
	localparam logic [3:0] ADDR_RES_HIGH = 4'hD;
	localparam logic [3:0] ADDR_RES_MID = 4'hE;
	localparam logic [3:0] ADDR_RES_LOW = 4'hF;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_BURNOUT = 3;
	localparam int BIT_READY = 7;
	localparam int BIT_UNIPOLAR = 6;
	localparam int BIT_SLOW_MOD = 5;
	localparam int BIT_BUFFER = 4;
	localparam int BIT_LSB_FIRST = 3;
	localparam int BIT_HALF_RANGE = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] RST_GAIN_LOW = 4'h0;
	localparam logic [7:0] RST_CHANNEL = 8'h01;
	localparam logic [6:0] RST_ANALOG = 7'h00;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam logic [7:0] RST_PIN_DATA = 8'h00;
	localparam logic [7:0] RST_PIN_DIR = 8'hFF;
	localparam logic [7:0] RST_PIN_FUNC = 8'h00;
	localparam logic [23:0] RST_OFS = 24'h000000;
	localparam logic [23:0] RST_FS = 24'h555559;

	// ----------------------------------------
	// Grouped configuration outputs
	// ----------------------------------------
	typedef struct packed {
		logic burnout_source_on;
		logic [2:0] amp_gain_code;
		logic [3:0] positive_input_code;
		logic [3:0] negative_input_code;
		logic unipolar;
		logic slow_modulator;
		logic input_buffer_on;
		logic lsb_first;
		logic half_range;
		logic [1:0] output_rate_code;
		logic [7:0] offset_trim;
	} analog_cfg_t;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b01,
		ACC_WRITE = 2'b10
	} access_state_t;

endpackage : adc_regs_pkg

// ==== bench/adc_regs_asserts.sv ====
// Port checker for the configuration register bank.
// Bound to every bank instance; sees only the bank's ports.
`timescale 1ns/1ps
`default_nettype none
module adc_regs_asserts
	import adc_regs_pkg::*;
#(
	parameter logic [3:0] IDENT_BITS = 4'hA
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [3:0] next_burst_addr,
	input wire logic [23:0] conversion_result,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_digital,
	input wire analog_cfg_t analog_cfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_read_answered: assert property (reg_read |=> reg_rvalid)
		else $error("read not answered");
	a_no_stray_valid: assert property (!reg_read |=> !reg_rvalid)
		else $error("valid without read");
	a_burst_wrap: assert property ((reg_read || reg_write) |=>
		next_burst_addr == 4'($past(reg_addr) + 4'h1))
		else $error("burst address wrong");
	a_result_high: assert property ((reg_read && reg_addr == 4'hD) |=>
		reg_rdata == $past(conversion_result[23:16]))
		else $error("result high byte wrong");
	a_ident_fixed: assert property ((reg_read && reg_addr == 4'h0) |=>
		reg_rdata[7:4] == IDENT_BITS)
		else $error("ident nibble changed");
	a_gain_applied: assert property ((reg_write && reg_addr == 4'h0) |=>
		##1 analog_cfg.amp_gain_code == $past(reg_wdata[2:0], 2))
		else $error("gain not applied");
	a_drive_digital: assert property ((pin_oe & ~pin_digital) == 8'h00)
		else $error("analog pin driven");
	a_out_masked: assert property ((pin_out & ~pin_oe) == 8'h00)
		else $error("pin data leaks");
endmodule : adc_regs_asserts
bind adc_config_register_map adc_regs_asserts #(.IDENT_BITS(IDENT_BITS))
	chk (.ref_clk, .rst_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
	.reg_rdata, .reg_rvalid, .next_burst_addr, .conversion_result,
	.pin_out, .pin_oe, .pin_digital, .analog_cfg);
`default_nettype wire

// ==== bench/adc_host_model.sv ====
// Command engine model: one-cycle read and write strobes.
// Drives at the falling edge; lines released show the inverse value.
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
	input wire logic ref_clk,
	output logic reg_write,
	output logic reg_read,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge ref_clk);
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(negedge ref_clk);
		reg_read = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_read = 1'b0;
		reg_addr = ~a;
		v = reg_rvalid ? reg_rdata : 8'hXX;
	endtask : rd
endmodule : adc_host_model
`default_nettype wire

// ==== bench/adc_config_register_map_bench.sv ====
// Self-checking bench for the configuration register bank.
// Host model issues accesses; pads and filter inputs driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module adc_config_register_map_bench;
	import adc_regs_pkg::*;
	localparam logic [3:0] IDENT = 4'h6; // arbitrary value
	logic ref_clk = 0, rst_n = 0, result_ready_n = 1;
	logic cal_ofs_load = 0, cal_fs_load = 0, reg_write, reg_read, reg_rvalid;
	logic [3:0] reg_addr, next_burst_addr;
	logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pin_digital, d;
	logic [7:0] ext = 8'h5A;
	logic [23:0] conversion_result = 24'hC396A5, offset_coef, full_scale_coef;
	logic [23:0] cal_ofs_value = 24'h123456, cal_fs_value = 24'hABCDEF;
	analog_cfg_t analog_cfg;
	int fails = 0, num_checks = 0, cyc = 0;
	logic [7:0] exp_rst [16] = '{{IDENT, 4'h0}, 8'h01, 8'h80, 8'h00, 8'h5A,
		8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h59, 8'h55, 8'h55, 8'hC3,
		8'h96, 8'hA5};
	always #5 ref_clk = ~ref_clk;
	// Pad level: driven bits from the bank, the rest from outside
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
	adc_config_register_map #(.PIN_COUNT(8), .IDENT_BITS(IDENT)) uut (
		.ref_clk, .rst_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .next_burst_addr, .result_ready_n,
		.conversion_result, .cal_ofs_load, .cal_ofs_value, .cal_fs_load,
		.cal_fs_value, .pin_in, .pin_out, .pin_oe, .pin_digital,
		.analog_cfg, .offset_coef, .full_scale_coef);
	adc_host_model host (.ref_clk, .reg_write, .reg_read, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid);
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1;
		repeat (6) @(negedge ref_clk);
		for (int i = 0; i < 16; i++) begin
			host.rd(i[3:0], d);
			`CHK(d, exp_rst[i])
		end
		`CHK(next_burst_addr, 4'h0)
		$display("reset table done");
		host.wr(ADDR_GAIN_BURNOUT, 8'hFF);
		host.wr(ADDR_ANALOG, 8'hFF);
		host.wr(ADDR_RES_HIGH, 8'h00);
		result_ready_n = 0;
		repeat (6) @(negedge ref_clk);
		`CHK({analog_cfg.burnout_source_on, analog_cfg.amp_gain_code}, 4'hF)
		`CHK(analog_cfg[14:8], 7'h7F)
		host.rd(ADDR_GAIN_BURNOUT, d);
		`CHK(d, {IDENT, 4'hF})
		host.rd(ADDR_ANALOG, d);
		`CHK(d, 8'h7F)
		host.rd(ADDR_RES_HIGH, d);
		`CHK(d, 8'hC3)
		$display("read-only done");
		for (int r = 0; r < 4; r++) begin
			host.wr(ADDR_ANALOG, {6'h00, r[1:0]});
			host.rd(ADDR_ANALOG, d);
			`CHK(d, {6'h00, r[1:0]})
			`CHK(analog_cfg.output_rate_code, r[1:0])
		end
		$display("rate codes done");
		@(negedge ref_clk) {cal_ofs_load, cal_fs_load} = 2'b11;
		@(negedge ref_clk) {cal_ofs_load, cal_fs_load} = 2'b00;
		@(negedge ref_clk);
		`CHK(full_scale_coef, cal_fs_value)
		`CHK(offset_coef, cal_ofs_value)
		for (int i = 0; i < 3; i++) begin
			host.rd(4'(ADDR_OFS_LOW + i), d);
			`CHK(d, cal_ofs_value[8*i +: 8])
		end
		host.wr(ADDR_TRIM, 8'h85);
		host.wr(ADDR_CHANNEL, 8'h73);
		@(negedge ref_clk);
		`CHK(analog_cfg.offset_trim, 8'h85)
		`CHK({analog_cfg.positive_input_code, analog_cfg.negative_input_code}, 8'h73)
		$display("calibration and channel done");
		host.wr(ADDR_PIN_FUNC, 8'h0F);
		host.wr(ADDR_PIN_DIR, 8'hF0);
		host.wr(ADDR_PIN_DATA, 8'hA5);
		repeat (6) @(negedge ref_clk);
		`CHK(pin_oe, 8'h0F)
		`CHK(pin_out, 8'h05)
		`CHK(pin_digital, 8'h0F)
		host.rd(ADDR_PIN_DATA, d);
		`CHK(d, 8'h55)
		$display("pins done");
		summarize();
	end
endmodule : adc_config_register_map_bench
`default_nettype wire
